/* File: shared/ncr_pkg.sv */
// Constants shared by the command-register device end and its bus host end.
// Assumes one 25 MHz core clock and a synchronous active-high reset.
// ==========================================================================
package ncr_pkg;

  // ==========================================================================
  // Device register map
  localparam logic [3:0] CMD_OFFSET = 4'h0; // Command register in every page
  localparam logic [3:0] RBC_LO_OFFSET = 4'ha; // Remote byte count, page 0
  localparam logic [3:0] RBC_HI_OFFSET = 4'hb;
  localparam logic [1:0] PAGE_ZERO = 2'h0;

  // Command register fields
  localparam int STOP_POS = 0;
  localparam int START_POS = 1;
  localparam int TXP_POS = 2;
  localparam int RD_LSB = 3;
  localparam int RD_MSB = 5;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_MSB = 7;
  localparam logic [7:0] CMD_RESET = 8'h21; // Stopped, abort code, page 0

  // Remote DMA command codes
  typedef enum logic [2:0]
  {
    RD_NONE = 3'h0,  // Not allowed, field ignored
    RD_READ = 3'h1,
    RD_WRITE = 3'h2,
    RD_SEND = 3'h3,
    RD_ABORT = 3'h4  // Any code with the top bit set
  } ncr_dma_e;

  // ==========================================================================
  // Host-side AHB register map (byte addresses, one word apart)
  localparam logic [7:0] H_ACCESS = 8'h00; // Launch access / busy and read data
  localparam logic [7:0] H_IRQ_STATUS = 8'h04;
  localparam logic [7:0] H_IRQ_MASK = 8'h08;
  localparam logic [7:0] H_LINK_STATE = 8'h0c;
  // Access word fields
  localparam int ACC_ADDR_LSB = 0;
  localparam int ACC_WDATA_LSB = 4;
  localparam int ACC_WRITE_POS = 12;
  localparam int ACC_BUSY_POS = 16;
  localparam int ACC_RDATA_LSB = 24;
  // Interrupt bits
  localparam int IRQ_DONE_POS = 0;  // Device access finished
  localparam int IRQ_RESET_POS = 1; // Reset-done flag rose
  localparam int IRQ_BITS = 2;

endpackage

/* File: shared/ncr_if.sv */
// Byte-wide register link between the bus host and the command-register device.
// Host holds req until it sees ack; device answers one cycle after taking it.
`timescale 1ns/1ps
interface ncr_if;
  logic req;        // Access request, held until ack
  logic we;         // High for a write
  logic [3:0] addr; // Register offset within the page
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;        // One-cycle answer
  logic reset_done; // Reset-done flag level

  modport dev
  (
    input req, we, addr, wdata,
    output rdata, ack, reset_done
  );

  modport host
  (
    output req, we, addr, wdata,
    input rdata, ack, reset_done
  );
endinterface

/* File: rtl/ncr_device.sv */
// Command register of the network core with its page decode and engine hand-off.
// Expects the host to hold req until ack; engines report busy levels and one-cycle done pulses.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module ncr_device
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register link
  ncr_if.dev BUS,
  // Page decoder side
  output logic [1:0] PAGE,
  output logic [3:0] REG_OFFSET,
  output logic [7:0] REG_WDATA,
  output logic REG_WE,
  output logic REG_RE,
  input wire logic [7:0] REG_RDATA,
  // Core state
  output logic CORE_ACTIVE,
  // Transmit engine
  output logic TX_START,
  input wire logic TX_BUSY,
  input wire logic TX_DONE,
  // Receive engine
  input wire logic RX_BUSY,
  // Remote DMA engine
  output ncr_pkg::ncr_dma_e DMA_CMD,
  output logic DMA_START,
  output logic DMA_ABORT,
  output logic DMA_FINISH,
  input wire logic DMA_DONE
);
  import ncr_pkg::*;

  // ==========================================================================
  // Access decode
  logic ack_q; // Answer strobe, also blocks retaking a held request
  logic [7:0] rdata_q;
  logic take;
  logic cmd_sel;
  logic cmd_wr;
  logic stop_q;
  logic start_q;
  logic txp_q;
  logic [2:0] rd_q;
  logic [1:0] page_q;
  logic dma_active_q;
  logic rbc_loaded_q; // Remote byte count rewritten since last start
  logic rst_done_q;
  logic [2:0] new_rd;
  logic rd_valid;
  logic same_rd;
  logic finish_now;
  logic dma_go;

  assign take = BUS.req && !ack_q;
  assign cmd_sel = BUS.addr == CMD_OFFSET;
  assign cmd_wr = take && BUS.we && cmd_sel;
  assign new_rd = BUS.wdata[RD_MSB:RD_LSB];
  // Codes 001..011 start work; 000 is refused and leaves the field alone
  assign rd_valid = !new_rd[2] && (new_rd != RD_NONE);
  assign same_rd = dma_active_q && (new_rd == rd_q);
  // Same command echoed with a transmit and no fresh count: finish at once
  assign finish_now = cmd_wr && rd_valid && same_rd && BUS.wdata[TXP_POS]
    && !rbc_loaded_q;
  // An echoed command is kept, and restarted only with a transmit and a fresh count
  assign dma_go = cmd_wr && rd_valid && !finish_now
    && (!same_rd || (BUS.wdata[TXP_POS] && rbc_loaded_q));

  // Other offsets go to the page decoder of the selected page
  assign PAGE = page_q;
  assign REG_OFFSET = BUS.addr;
  assign REG_WDATA = BUS.wdata;
  assign REG_WE = take && BUS.we && !cmd_sel;
  assign REG_RE = take && !BUS.we && !cmd_sel;

  // ==========================================================================
  // Link answer
  // Answer one cycle after the request is taken
  always_ff @(posedge CLK)
  begin
    if (RESET)
      ack_q <= 1'b0;
    else
      ack_q <= take;
  end

  // Read data; command reads show live bits, including a pending transmit
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rdata_q <= 8'h00;
    else if (take && !BUS.we)
    begin
      if (cmd_sel)
        rdata_q <= {page_q, rd_q, txp_q, start_q, stop_q};
      else
        rdata_q <= REG_RDATA;
    end
  end

  assign BUS.ack = ack_q;
  assign BUS.rdata = rdata_q;

  // ==========================================================================
  // Stop, start and software reset
  // Stop is accepted whatever else is running
  always_ff @(posedge CLK)
  begin
    if (RESET)
      stop_q <= CMD_RESET[STOP_POS];
    else if (cmd_wr)
      stop_q <= BUS.wdata[STOP_POS];
  end

  // Start comes up clear and is the core's run request
  always_ff @(posedge CLK)
  begin
    if (RESET)
      start_q <= CMD_RESET[START_POS];
    else if (cmd_wr)
      start_q <= BUS.wdata[START_POS];
  end

  // New packets only while started and not stopped
  assign CORE_ACTIVE = start_q && !stop_q;

  // Reset is done only once frames in flight have drained
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rst_done_q <= 1'b0;
    else if (stop_q && !TX_BUSY && !RX_BUSY)
      rst_done_q <= 1'b1;
    else if (!stop_q)
      rst_done_q <= 1'b0;
  end

  assign BUS.reset_done = rst_done_q;

  // ==========================================================================
  // Transmit
  // A zero in the bit is no command, so a DMA-only write leaves it alone
  always_ff @(posedge CLK)
  begin
    if (RESET)
      txp_q <= CMD_RESET[TXP_POS];
    else if (cmd_wr && BUS.wdata[TXP_POS] && !stop_q && !txp_q)
      txp_q <= 1'b1;
    else if (TX_DONE)
      txp_q <= 1'b0;
  end

  // Launch pulse; refused while stopped so no new frame leaves
  always_ff @(posedge CLK)
  begin
    if (RESET)
      TX_START <= 1'b0;
    else
      TX_START <= cmd_wr && BUS.wdata[TXP_POS] && !stop_q && !txp_q;
  end

  // ==========================================================================
  // Remote DMA
  // Command field; completion writes back the abort/complete code
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rd_q <= CMD_RESET[RD_MSB:RD_LSB];
    else if (cmd_wr && new_rd[2])
      rd_q <= RD_ABORT;
    else if (finish_now)
      rd_q <= RD_ABORT;
    else if (dma_go)
      rd_q <= new_rd;
    else if (DMA_DONE)
      rd_q <= RD_ABORT;
  end

  // Activity flag; a start in the done cycle wins over the clear
  always_ff @(posedge CLK)
  begin
    if (RESET)
      dma_active_q <= 1'b0;
    else if (dma_go)
      dma_active_q <= 1'b1;
    else if ((cmd_wr && new_rd[2]) || finish_now || DMA_DONE)
      dma_active_q <= 1'b0;
  end

  // Tracks a fresh byte count so an echoed command can restart
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rbc_loaded_q <= 1'b0;
    else if (take && BUS.we && page_q == PAGE_ZERO
             && (BUS.addr == RBC_LO_OFFSET || BUS.addr == RBC_HI_OFFSET))
      rbc_loaded_q <= 1'b1;
    else if (dma_go || finish_now)
      rbc_loaded_q <= 1'b0;
  end

  // Engine strobes; abort only stops the engine, its address counters hold
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      DMA_START <= 1'b0;
      DMA_ABORT <= 1'b0;
      DMA_FINISH <= 1'b0;
    end
    else
    begin
      DMA_START <= dma_go;
      DMA_ABORT <= cmd_wr && new_rd[2] && dma_active_q;
      DMA_FINISH <= finish_now;
    end
  end

  assign DMA_CMD = ncr_dma_e'(rd_q);

  // ==========================================================================
  // Page select, writable at any time
  always_ff @(posedge CLK)
  begin
    if (RESET)
      page_q <= CMD_RESET[PAGE_MSB:PAGE_LSB];
    else if (cmd_wr)
      page_q <= BUS.wdata[PAGE_MSB:PAGE_LSB];
  end

endmodule

/* File: rtl/ncr_host.sv */
// Host end: an AHB-Lite slave whose own registers drive byte accesses on the link.
// Software keeps the ordering duties of the command register; this end only carries them.
`timescale 1ns/1ps
module ncr_host
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Interrupt
  output logic IRQ,
  // Register link
  ncr_if.host LINK
);
  import ncr_pkg::*;

  // ==========================================================================
  // Bus front end
  logic wr_pend_q; // Write address phase seen, data comes now
  logic [7:0] wa_q;
  logic [7:0] ra;
  logic rd_phase_q;
  logic [7:0] ra_q;
  logic busy_q;
  logic req_q;
  logic we_q;
  logic [3:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [IRQ_BITS-1:0] stat_q;
  logic [IRQ_BITS-1:0] mask_q;
  logic rst_seen_q;
  logic aphase;
  logic wr;
  logic launch;
  logic [IRQ_BITS-1:0] evt;

  // Zero wait states; only whole-word transfers are expected
  assign aphase = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign wr = wr_pend_q;

  // Capture address phase
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      wr_pend_q <= 1'b0;
      rd_phase_q <= 1'b0;
      wa_q <= 8'h00;
      ra_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= aphase && HWRITE;
      rd_phase_q <= aphase && !HWRITE;
      wa_q <= HADDR[7:0];
      ra_q <= HADDR[7:0];
    end
  end

  // Read mux in the data phase; unmapped words read zero
  assign ra = ra_q;
  always_comb
  begin
    HRDATA = 32'h0000_0000;
    if (rd_phase_q)
    begin
      unique case (ra)
        H_ACCESS: HRDATA = {rdata_q, 7'h00, busy_q, 3'h0, we_q, wdata_q, addr_q};
        H_IRQ_STATUS: HRDATA = {30'h0, stat_q};
        H_IRQ_MASK: HRDATA = {30'h0, mask_q};
        H_LINK_STATE: HRDATA = {31'h0, LINK.reset_done};
        default: HRDATA = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Link access engine
  // A write to the access word while idle launches one byte access
  assign launch = wr && wa_q == H_ACCESS && !busy_q;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      busy_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 4'h0;
      wdata_q <= 8'h00;
    end
    else if (launch)
    begin
      busy_q <= 1'b1;
      req_q <= 1'b1;
      we_q <= HWDATA[ACC_WRITE_POS];
      addr_q <= HWDATA[ACC_ADDR_LSB +: 4];
      wdata_q <= HWDATA[ACC_WDATA_LSB +: 8];
    end
    else if (LINK.ack)
    begin
      busy_q <= 1'b0;
      req_q <= 1'b0;
    end
  end

  // Latch the answer byte of a read
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rdata_q <= 8'h00;
    else if (LINK.ack && !we_q)
      rdata_q <= LINK.rdata;
  end

  assign LINK.req = req_q;
  assign LINK.we = we_q;
  assign LINK.addr = addr_q;
  assign LINK.wdata = wdata_q;

  // ==========================================================================
  // Interrupts
  // Rising edge of the reset-done flag
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rst_seen_q <= 1'b0;
    else
      rst_seen_q <= LINK.reset_done;
  end

  assign evt = {LINK.reset_done && !rst_seen_q, LINK.ack};

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge CLK)
  begin
    if (RESET)
      stat_q <= '0;
    else if (wr && wa_q == H_IRQ_STATUS)
      stat_q <= (stat_q & ~HWDATA[IRQ_BITS-1:0]) | evt;
    else
      stat_q <= stat_q | evt;
  end

  // Mask, one enables the bit
  always_ff @(posedge CLK)
  begin
    if (RESET)
      mask_q <= '0;
    else if (wr && wa_q == H_IRQ_MASK)
      mask_q <= HWDATA[IRQ_BITS-1:0];
  end

  assign IRQ = |(stat_q & mask_q);

endmodule

/* File: verif/ncr_monitor.sv */
// Checker for the byte link joining the bus host end and the command device end.
// Instantiated beside the link interface; it sees only the link's signals.
`timescale 1ns/1ps
module ncr_monitor
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Request side
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  // Answer side
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic reset_done
);
  // ==========
  // Helper state
  logic take; // Request taken at this edge
  logic [7:0] cmd_q; // Shadow of the last command byte written
  assign take = req && !ack;
  // Only the always-copied bits of the shadow are trusted below
  always_ff @(posedge CLK)
  begin
    if (RESET)
      cmd_q <= 8'h21;
    else if (take && we && addr == 4'h0)
      cmd_q <= wdata;
  end
  // ==========
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  ack_after_take_a:
    assert property (take |=> ack) else $error("link answer missing");
  ack_single_a:
    assert property (ack |=> !ack) else $error("link answer too long");
  ack_cause_a:
    assert property ($rose(ack) |-> $past(req)) else $error("answer without request");
  req_drop_a:
    assert property (ack |=> !req) else $error("request kept after answer");
  req_hold_a:
    assert property (take |=> req && $stable(addr) && $stable(we) && $stable(wdata))
      else $error("request changed before answer");
  rdata_hold_a:
    assert property (!(take && !we) |=> $stable(rdata)) else $error("read data moved");
  cmd_read_a:
    assert property (ack && !$past(we) && $past(addr) == 4'h0 |->
      rdata[7:6] == cmd_q[7:6] && rdata[1:0] == cmd_q[1:0]) else $error("command read wrong");
  done_needs_stop_a:
    assert property ($rose(reset_done) |-> cmd_q[0]) else $error("done flag while running");
  done_clears_a:
    assert property ($fell(cmd_q[0]) |-> ##[0:1] !reset_done) else $error("done flag stuck");
  // Main scenarios
  cmd_read_c: cover property (ack && !$past(we) && $past(addr) == 4'h0);
  cmd_write_c: cover property (take && we && addr == 4'h0);
  done_rise_c: cover property ($rose(reset_done));
endmodule

/* File: verif/nic_command_register_tb_top.sv */
// Self-checking bench: host end on AHB-Lite, device end with engine stubs.
// Assumes a 25 MHz clock and one link interface joining both ends.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module nic_command_register_tb_top;
  import ncr_pkg::*;
  // ==========
  // Signals
  logic clk, rst; // Clock and reset
  logic hsel, hwrite, hready, irq; // Bus control
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] page; // Current page
  logic [7:0] reg_rdata; // Page register read stub
  logic [3:0] reg_off; // Page register write seen by the decoder
  logic [7:0] reg_wd;
  logic reg_we;
  logic [11:0] w_pg; // Last page register write, offset and data
  logic active, tx_start, tx_busy, tx_done, rx_busy;
  logic ds, da, df, dma_done; // DMA engine pulses
  ncr_dma_e dma_cmd;
  int n_errors, checks, n_tx, n_ds, n_da, n_df; // Counters
  int m_cmd, m_tx, m_ds, m_da, m_df; // Model state
  bit m_act; // Model: remote DMA running
  bit m_rbc; // Model: remote byte count rewritten since last start
  logic [31:0] seed; // Random state
  ncr_if link();
  // ==========
  // Instances
  ncr_host i_ncr_host (.CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .IRQ(irq), .LINK(link));
  ncr_device i_ncr_device (.CLK(clk), .RESET(rst), .BUS(link), .PAGE(page),
    .REG_OFFSET(reg_off), .REG_WDATA(reg_wd), .REG_WE(reg_we), .REG_RE(),
    .REG_RDATA(reg_rdata),
    .CORE_ACTIVE(active), .TX_START(tx_start), .TX_BUSY(tx_busy), .TX_DONE(tx_done),
    .RX_BUSY(rx_busy), .DMA_CMD(dma_cmd), .DMA_START(ds), .DMA_ABORT(da),
    .DMA_FINISH(df), .DMA_DONE(dma_done));
  ncr_monitor i_ncr_monitor (.CLK(clk), .RESET(rst), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
    .reset_done(link.reset_done));
  // ==========
  // Clock and pulse counting
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Engine pulses are counted so the model can judge each result
  always @(posedge clk)
  begin
    n_tx += (tx_start === 1'b1);
    n_ds += (ds === 1'b1);
    n_da += (da === 1'b1);
    n_df += (df === 1'b1);
    // Page register writes are kept so each one can be checked at the decoder
    if (reg_we === 1'b1)
      w_pg = {reg_off, reg_wd};
  end
  // ==========
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Model of one command write
  function automatic void mwr(int d);
    int c;
    int rd;
    c = (d >> 3) & 7;
    rd = (m_cmd >> 3) & 7;
    if ((d & 4) && !(m_cmd & 5))
    begin
      m_cmd |= 4;
      m_tx++;
    end
    if (c >= 4)
    begin
      m_da += m_act;
      m_act = 0;
      c = 4;
    end
    else if (c == 0)
      c = rd;
    else if (m_act && c == rd && (d & 4) && !m_rbc)
    begin
      m_df++;
      m_act = 0;
      m_rbc = 0;
      c = 4;
    end
    // An echo restarts only with a transmit and a fresh byte count
    else if (!(m_act && c == rd) || (d & 4))
    begin
      m_ds++;
      m_act = 1;
      m_rbc = 0;
    end
    m_cmd = (d & 8'hc3) | (m_cmd & 4) | (c << 3);
  endfunction
  // One AHB single transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  // One device access through the host's access register
  task automatic dev(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [31:0] r;
    ahb(H_ACCESS, 1'b1, {19'h0, w, d, a}, r);
    r = 32'h1 << ACC_BUSY_POS;
    while (r[ACC_BUSY_POS] !== 1'b0) ahb(H_ACCESS, 1'b0, 32'h0, r);
    q = r[ACC_RDATA_LSB+:8];
  endtask
  task automatic wc(int d);
    logic [7:0] q;
    dev(1'b1, 4'h0, d[7:0], q);
    mwr(d);
  endtask
  // Write one page register; the decoder must see that offset and byte
  task automatic pw(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev(1'b1, a, d, q);
    `CHK(w_pg, {a, d})
    m_rbc |= (m_cmd >> 6) == 0 && (a == RBC_LO_OFFSET || a == RBC_HI_OFFSET);
  endtask
  // Compare the command byte and every pulse count with the model
  task automatic chk();
    logic [7:0] q;
    dev(1'b0, 4'h0, 8'h00, q);
    `CHK(q, m_cmd[7:0])
    `CHK(n_tx, m_tx)
    `CHK(n_ds, m_ds)
    `CHK(n_da, m_da)
    `CHK(n_df, m_df)
  endtask
  // One-cycle completion pulse from the transmit or DMA engine
  task automatic fin(bit t);
    if (t)
      tx_done <= 1'b1;
    else
      dma_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    dma_done <= 1'b0;
    tx_busy <= 1'b0;
    if (t)
      m_cmd &= ~4;
    else
      m_cmd = (m_cmd & 8'hc7) | 8'h20;
    m_act = t ? m_act : 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog: the tests need a few hundred cycles
  initial
  begin
    #800000;
    n_errors++;
    final_report();
  end
  // ==========
  // Tests
  initial
  begin
    logic [31:0] r;
    logic [7:0] q;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {reg_rdata, tx_busy, tx_done, rx_busy, dma_done} = '0;
    seed = 32'h0000d33c;
    m_cmd = 32'h21;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // Reset-done event raises the interrupt only when unmasked
    ahb(H_IRQ_STATUS, 1'b0, 32'h0, r);
    `CHK(r[1:0], 2'h2)
    `CHK(irq, 1'b0)
    ahb(H_IRQ_MASK, 1'b1, 32'h2, r);
    @(posedge clk);
    `CHK(irq, 1'b1)
    ahb(H_IRQ_STATUS, 1'b1, 32'h2, r);
    @(posedge clk);
    `CHK(irq, 1'b0)
    ahb(8'h40, 1'b0, 32'h0, r);
    `CHK(r, 32'h0)
    chk();
    $display("test reset finished");
    // Every page, with a random register offset inside it
    for (int p = 0; p < 4; p++)
    begin
      wc(32'h21 | (p << 6));
      `CHK(page, p[1:0])
      r = xs();
      reg_rdata <= r[7:0];
      dev(1'b0, 4'h1 + (r[11:8] % 4'hf), 8'h00, q);
      `CHK(q, r[7:0])
      chk();
    end
    $display("test pages finished");
    // Start, then stop with reception still busy
    wc(32'h22);
    `CHK(active, 1'b1)
    ahb(H_LINK_STATE, 1'b0, 32'h0, r);
    `CHK(r[0], 1'b0)
    rx_busy <= 1'b1;
    wc(32'h21);
    `CHK(active, 1'b0)
    ahb(H_LINK_STATE, 1'b0, 32'h0, r);
    `CHK(r[0], 1'b0)
    rx_busy <= 1'b0;
    repeat (2) @(posedge clk);
    ahb(H_LINK_STATE, 1'b0, 32'h0, r);
    `CHK(r[0], 1'b1)
    // A transmit asked for while stopped is refused
    wc(32'h25);
    chk();
    $display("test stop finished");
    // Transmit: zero written and repeat set while pending change nothing
    wc(32'h22);
    pw(4'h4, 8'h40);
    pw(4'h5, 8'h3c);
    pw(4'h6, 8'h00);
    wc(32'h26);
    tx_busy <= 1'b1;
    chk();
    wc(32'h22);
    wc(32'h26);
    chk();
    fin(1'b1);
    chk();
    $display("test transmit finished");
    // Every remote DMA code, then keep, abort and immediate finish
    for (int c = 1; c < 4; c++)
    begin
      wc(32'h02 | (c << 3));
      `CHK(dma_cmd, c[2:0])
      chk();
      fin(1'b0);
      chk();
    end
    wc(32'h0a);
    wc(32'h02);
    `CHK(dma_cmd, RD_READ)
    wc(32'h22);
    chk();
    wc(32'h0a);
    wc(32'h0e);
    chk();
    fin(1'b1);
    chk();
    // A rewritten byte count makes the echoed command restart instead
    wc(32'h0a);
    r = xs();
    pw(RBC_LO_OFFSET, r[7:0]);
    wc(32'h0e);
    chk();
    fin(1'b1);
    wc(32'h3a);
    chk();
    $display("test dma finished");
    final_report();
  end
endmodule
